// *** gms_sequencer.sv ***
// What this block does
// [RULE1] repeat the full sequence back to back while active
// [RULE2] divider supply on a settle time before each aux conversion
// [RULE3] divider supply stays off during an internal temperature slot
// [RULE4] one full sequence is two halves, 1760 ms nominal
// [RULE5] voltage result refreshed every 880 ms, two's complement
// [RULE6] voltage above range reads 7fff
// [RULE7] every 1024th voltage conversion measures offset, corrects next 1023
// [RULE8] voltage result held during its offset conversion
// [RULE9] aux inputs alternate, each refreshed every 1760 ms
// [RULE10] temperature refreshed every 1760 ms, two's complement
// [RULE11] temperature replaces second aux slot only while select bit set
// [RULE12] current positive when sense input is below ground
// [RULE13] current result updated every 880 ms at end of conversion
// [RULE14] current saturates to 7fff and 8000
// [RULE15] every 1024th current conversion is offset, result held meanwhile
// [RULE16] bias added to raw current; biased value reported and accumulated
// [RULE17] new bias applies to every later current conversion
// [RULE18] bias is signed 25 uV steps, default 00
// [RULE19] biased current summed into signed charge counter each period
// [RULE20] charge counter times capacity factor moves relative capacity
// [RULE21] current below blanking threshold leaves counter unchanged
// [RULE22] in sleep no conversions, results unchanged
// [RULE23] each half: voltage, current, then alternating aux slot
// [RULE24] charge counter clamps at its range limits
module gms_sequencer #(
   parameter int HALF_CYCLES = gms_pkg::HALF_CYCLES,
   parameter int SETTLE_CYCLES = gms_pkg::SETTLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [gms_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic active_mode,
   output logic adc_start,
   output gms_pkg::gms_chan_e adc_sel,
   input wire logic adc_done,
   input wire logic [15:0] adc_data,
   output logic divider_supply_out
);
   import gms_pkg::*;

   // saturate an 18 bit signed value to a 16 bit code
   function automatic logic [15:0] sat16(input logic signed [17:0] x);
      logic [15:0] r;
      r = x[15:0];
      if (x > SAT16_MAX) begin
         r = SAT_POS;
      end else if (x < SAT16_MIN) begin
         r = SAT_NEG;
      end
      return r;
   endfunction

   // ***********************************************
   // state
   // ***********************************************
   gms_state_e state_reg, state_next;
   logic [TIMER_W-1:0] half_cnt_reg;
   logic [TIMER_W-1:0] settle_cnt_reg;
   logic half_reg;
   logic [OFS_W-1:0] vcnt_reg, icnt_reg;
   logic [15:0] vofs_reg, iofs_reg;
   logic [15:0] volt_reg, cur_reg, aux0_reg, aux1_reg, temp_reg;
   logic [1:0] ctrl_reg;
   logic [7:0] bias_reg, blank_reg, init_scale_reg, learn_scale_reg, base_cap_reg;
   logic signed [31:0] acc_reg;
   logic [7:0] rel_cap_reg;
   logic adc_start_reg;
   gms_chan_e adc_sel_reg;
   logic div_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // ***********************************************
   // sequence decode
   // ***********************************************
   wire half_tick = (half_cnt_reg == TIMER_W'(HALF_CYCLES - 1));
   wire settle_done = (settle_cnt_reg == TIMER_W'(SETTLE_CYCLES - 1));
   wire temp_slot = half_reg & ctrl_reg[CTRL_INTERNAL_TEMP_SELECT_BIT]; // see [RULE11]
   wire aux_div = ~temp_slot; // see [RULE3]
   wire v_ofs = (vcnt_reg == OFS_SLOT); // see [RULE7]
   wire i_ofs = (icnt_reg == OFS_SLOT); // see [RULE15]
   wire conv_v = (state_reg == ST_VOLT) & adc_done;
   wire conv_i = (state_reg == ST_CUR) & adc_done;
   wire conv_a = (state_reg == ST_AUX) & adc_done;
   wire go_volt = (state_next == ST_VOLT) & (state_reg != ST_VOLT);
   wire go_cur = (state_next == ST_CUR) & (state_reg != ST_CUR);
   wire go_aux = (state_next == ST_AUX) & (state_reg != ST_AUX);
   wire gms_chan_e aux_chan = temp_slot ? CH_TEMP : (half_reg ? CH_AUX1 : CH_AUX0);
   wire gms_chan_e sel_next = go_volt ? (v_ofs ? CH_VOFS : CH_VOLT) :
                              go_cur ? (i_ofs ? CH_IOFS : CH_CUR) : aux_chan;
   // divider choice is frozen once the aux slot runs, a late select write cannot flip it
   wire div_hold = (state_reg == ST_AUX) ? div_reg : aux_div; // see [RULE3]
   wire div_next = active_mode & ((state_next == ST_SETTLE) |
                   ((state_next == ST_AUX) & div_hold)); // see [RULE2]

   // next state: V, I, optional settle, aux, then wait for the half to end
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            state_next = ST_VOLT; // see [RULE1]
         end
         ST_VOLT: begin
            if (adc_done) begin
               state_next = ST_CUR; // see [RULE23]
            end
         end
         ST_CUR: begin
            if (adc_done) begin
               state_next = aux_div ? ST_SETTLE : ST_AUX; // see [RULE2] [RULE3]
            end
         end
         ST_SETTLE: begin
            if (settle_done) begin
               state_next = ST_AUX;
            end
         end
         ST_AUX: begin
            if (adc_done) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (half_tick) begin
               state_next = ST_VOLT; // see [RULE1] [RULE4]
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (!active_mode) begin
         state_next = ST_IDLE; // see [RULE22]
      end
   end

   // state and half-sequence timers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         half_cnt_reg <= '0;
         settle_cnt_reg <= '0;
         half_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         half_cnt_reg <= (state_reg == ST_IDLE || half_tick) ? '0 : half_cnt_reg + 1'b1;
         settle_cnt_reg <= (state_reg == ST_SETTLE) ? settle_cnt_reg + 1'b1 : '0;
         if (state_reg == ST_WAIT && half_tick) begin
            half_reg <= ~half_reg; // see [RULE9] [RULE4]
         end
      end
   end

   // converter request and divider supply
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         adc_start_reg <= 1'b0;
         adc_sel_reg <= CH_VOLT;
         div_reg <= 1'b0;
      end else begin
         adc_start_reg <= go_volt | go_cur | go_aux;
         if (go_volt | go_cur | go_aux) begin
            adc_sel_reg <= sel_next;
         end
         div_reg <= div_next;
      end
   end

   assign adc_start = adc_start_reg;
   assign adc_sel = adc_sel_reg;
   assign divider_supply_out = div_reg;

   // ***********************************************
   // voltage path
   // ***********************************************
   wire signed [17:0] v_diff = {{2{adc_data[15]}}, adc_data} - {{2{vofs_reg[15]}}, vofs_reg};

   // offset slot counters and corrections
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         vcnt_reg <= '0;
         icnt_reg <= '0;
         vofs_reg <= RESULT_RST;
         iofs_reg <= RESULT_RST;
      end else begin
         if (conv_v) begin
            vcnt_reg <= vcnt_reg + 1'b1;
         end
         if (conv_i) begin
            icnt_reg <= icnt_reg + 1'b1;
         end
         if (conv_v && v_ofs) begin
            vofs_reg <= adc_data; // see [RULE7]
         end
         if (conv_i && i_ofs) begin
            iofs_reg <= adc_data; // see [RULE15]
         end
      end
   end

   // ***********************************************
   // current path
   // ***********************************************
   wire signed [17:0] i_corr = {{2{iofs_reg[15]}}, iofs_reg} - {{2{adc_data[15]}}, adc_data};
   wire signed [17:0] i_bias = i_corr + {{10{bias_reg[7]}}, bias_reg}; // see [RULE16] [RULE17]
   wire i_hi = (i_bias > CUR_UNIT_MAX);
   wire i_lo = (i_bias < CUR_UNIT_MIN);
   wire [11:0] cur_units = i_hi ? CUR_CLAMP_POS : (i_lo ? CUR_CLAMP_NEG : i_bias[11:0]);
   wire [15:0] cur_word = i_hi ? SAT_POS : (i_lo ? SAT_NEG : {i_bias[11:0], CUR_PAD});
   wire [11:0] cur_abs = cur_units[11] ? 12'h000 - cur_units : cur_units;
   wire cur_blank = (cur_abs < {4'h0, blank_reg});
   wire signed [32:0] acc_sum = {acc_reg[31], acc_reg} + {{21{cur_units[11]}}, cur_units};
   wire signed [32:0] acc_pos = {ACC_LIMIT[31], ACC_LIMIT};
   wire signed [32:0] acc_neg = -acc_pos;
   wire [31:0] acc_clamp = (acc_sum > acc_pos) ? ACC_LIMIT :
                           ((acc_sum < acc_neg) ? -ACC_LIMIT : acc_sum[31:0]);
   wire [7:0] scale = ctrl_reg[CTRL_LEARNED_BIT] ? learn_scale_reg : init_scale_reg;
   wire signed [40:0] cap_prod = acc_reg * $signed({1'b0, scale});
   wire signed [40:0] cap_sum = (cap_prod >>> CAP_SHIFT) + $signed({33'h0, base_cap_reg});
   wire [7:0] cap_clamp = cap_sum[40] ? 8'h00 : ((cap_sum > CAP_MAX) ? CAP_MAX[7:0] :
                          cap_sum[7:0]);

   // ***********************************************
   // bus decode
   // ***********************************************
   wire bus_req = avs_read | avs_write;
   wire wr_en = avs_write & ack_reg;
   wire wr_ctrl = wr_en & (avs_address == A_CTRL);
   wire wr_bias = wr_en & (avs_address == A_BIAS);
   wire wr_blank = wr_en & (avs_address == A_BLANK);
   wire wr_acc = wr_en & (avs_address == A_ACC);
   wire wr_init = wr_en & (avs_address == A_INIT_SCALE);
   wire wr_learn = wr_en & (avs_address == A_LEARN_SCALE);
   wire wr_base = wr_en & (avs_address == A_BASE_CAP);
   logic [31:0] rd_mux;

   // read selection, unmapped reads zero
   always_comb begin
      case (avs_address)
         A_CTRL: rd_mux = {30'h0, ctrl_reg};
         A_VOLT: rd_mux = {16'h0, volt_reg};
         A_CUR: rd_mux = {16'h0, cur_reg};
         A_AUX0: rd_mux = {16'h0, aux0_reg};
         A_AUX1: rd_mux = {16'h0, aux1_reg};
         A_TEMP: rd_mux = {16'h0, temp_reg};
         A_BIAS: rd_mux = {24'h0, bias_reg};
         A_BLANK: rd_mux = {24'h0, blank_reg};
         A_ACC: rd_mux = acc_reg;
         A_INIT_SCALE: rd_mux = {24'h0, init_scale_reg};
         A_LEARN_SCALE: rd_mux = {24'h0, learn_scale_reg};
         A_BASE_CAP: rd_mux = {24'h0, base_cap_reg};
         A_REL_CAP: rd_mux = {24'h0, rel_cap_reg};
         A_STATUS: rd_mux = {29'h0, div_reg, half_reg, active_mode};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // one wait state, then the transfer completes
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         if (avs_read && !ack_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign avs_waitrequest = bus_req & ~ack_reg;
   assign avs_readdata = rdata_reg;

   // ***********************************************
   // software registers
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_reg <= CTRL_RST;
         bias_reg <= BIAS_RST; // see [RULE18]
         blank_reg <= BLANK_RST;
         init_scale_reg <= SCALE_RST;
         learn_scale_reg <= SCALE_RST;
         base_cap_reg <= BASE_CAP_RST;
      end else begin
         if (wr_ctrl) ctrl_reg <= avs_writedata[1:0];
         if (wr_bias) bias_reg <= avs_writedata[7:0];
         if (wr_blank) blank_reg <= avs_writedata[7:0];
         if (wr_init) init_scale_reg <= avs_writedata[7:0];
         if (wr_learn) learn_scale_reg <= avs_writedata[7:0];
         if (wr_base) base_cap_reg <= avs_writedata[7:0];
      end
   end

   // ***********************************************
   // result registers
   // ***********************************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         volt_reg <= RESULT_RST;
         cur_reg <= RESULT_RST;
         aux0_reg <= RESULT_RST;
         aux1_reg <= RESULT_RST;
         temp_reg <= RESULT_RST;
      end else begin
         if (conv_v && !v_ofs) begin
            volt_reg <= sat16(v_diff); // see [RULE5] [RULE6] [RULE8]
         end
         if (conv_i && !i_ofs) begin
            cur_reg <= cur_word; // see [RULE12] [RULE13] [RULE14]
         end
         if (conv_a && adc_sel_reg == CH_AUX0) aux0_reg <= adc_data; // see [RULE9]
         if (conv_a && adc_sel_reg == CH_AUX1) aux1_reg <= adc_data;
         if (conv_a && adc_sel_reg == CH_TEMP) temp_reg <= adc_data; // see [RULE10]
      end
   end

   // charge counter and relative capacity, hardware update beats a software write
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         acc_reg <= '0;
         rel_cap_reg <= BASE_CAP_RST;
      end else begin
         if (conv_i && !i_ofs) begin
            if (!cur_blank) begin
               acc_reg <= acc_clamp; // see [RULE19] [RULE21] [RULE24]
            end
            rel_cap_reg <= cap_clamp; // see [RULE20]
         end else if (wr_acc) begin
            acc_reg <= avs_writedata;
         end
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   temp_div_off_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE3]
      (state_reg == ST_AUX && adc_sel == CH_TEMP) |-> !divider_supply_out)
      else $error("divider on during temperature slot");
   aux_settled_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE2]
      (adc_start && (adc_sel == CH_AUX0 || adc_sel == CH_AUX1)) |->
      divider_supply_out && $past(divider_supply_out, 2))
      else $error("aux conversion started without settled divider");
   volt_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE8]
      (conv_v && adc_sel == CH_VOFS) |=> $stable(volt_reg))
      else $error("voltage result changed on offset conversion");
   cur_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE15]
      (conv_i && adc_sel == CH_IOFS) |=> $stable(cur_reg) && $stable(acc_reg))
      else $error("current result changed on offset conversion");
   sleep_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE22]
      (!active_mode && !$past(active_mode)) |-> !adc_start && !divider_supply_out)
      else $error("activity while asleep");
   seq_order_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE23]
      (conv_v && active_mode) |=> adc_start && adc_sel inside {CH_CUR, CH_IOFS})
      else $error("current conversion did not follow voltage");
   acc_range_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE24]
      (conv_i && !i_ofs && !cur_blank) |=> (acc_reg <= ACC_LIMIT) && (acc_reg >= -ACC_LIMIT))
      else $error("charge counter out of range");
   blank_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RULE21]
      (conv_i && !i_ofs && cur_blank) |=> $stable(acc_reg))
      else $error("blanked current accumulated");
   bus_answer_a: assert property (@(posedge sys_clk) disable iff (srst)
      (bus_req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer later than one wait state");

endmodule // gms_sequencer

// *** gms_pkg.sv ***
package gms_pkg;

   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_KHZ = 10000; // sys_clk rate, 10 MHz
   localparam int HALF_MS = 880; // half sequence, one V, I and aux slot
   localparam int HALF_CYCLES = HALF_MS * CLK_KHZ;
   localparam int SETTLE_MS = 10; // divider settle time before aux sampling
   localparam int SETTLE_CYCLES = SETTLE_MS * CLK_KHZ;
   localparam int TIMER_W = 24;

   // ***********************************************
   // offset calibration and scaling
   // ***********************************************
   localparam int OFS_W = 10;
   localparam logic [OFS_W-1:0] OFS_SLOT = 10'h3ff; // every 1024th conversion
   localparam logic signed [17:0] SAT16_MAX = 18'sh07fff;
   localparam logic signed [17:0] SAT16_MIN = -18'sh08000;
   localparam logic [15:0] SAT_POS = 16'h7fff;
   localparam logic [15:0] SAT_NEG = 16'h8000;
   localparam logic signed [17:0] CUR_UNIT_MAX = 18'sh007ff; // +51.2 mV in 25 uV units
   localparam logic signed [17:0] CUR_UNIT_MIN = -18'sh00800; // -51.2 mV
   localparam logic [11:0] CUR_CLAMP_POS = 12'h7ff;
   localparam logic [11:0] CUR_CLAMP_NEG = 12'h800;
   localparam logic [3:0] CUR_PAD = 4'h0; // current code sits in bits 15:4
   localparam logic signed [31:0] ACC_LIMIT = 32'sh01ff5ff7; // 204.8 mVh in 25 uV x 880 ms
   localparam int CAP_SHIFT = 20; // acc x scale to 0.5 % units
   localparam logic signed [40:0] CAP_MAX = 41'sh000000000c8; // 100 %

   // ***********************************************
   // register map, byte addresses
   // ***********************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] A_VOLT = 8'h04;
   localparam logic [ADDR_W-1:0] A_CUR = 8'h08;
   localparam logic [ADDR_W-1:0] A_AUX0 = 8'h0c;
   localparam logic [ADDR_W-1:0] A_AUX1 = 8'h10;
   localparam logic [ADDR_W-1:0] A_TEMP = 8'h14;
   localparam logic [ADDR_W-1:0] A_BIAS = 8'h18;
   localparam logic [ADDR_W-1:0] A_BLANK = 8'h1c;
   localparam logic [ADDR_W-1:0] A_ACC = 8'h20;
   localparam logic [ADDR_W-1:0] A_INIT_SCALE = 8'h24;
   localparam logic [ADDR_W-1:0] A_LEARN_SCALE = 8'h28;
   localparam logic [ADDR_W-1:0] A_BASE_CAP = 8'h2c;
   localparam logic [ADDR_W-1:0] A_REL_CAP = 8'h30;
   localparam logic [ADDR_W-1:0] A_STATUS = 8'h34;
   localparam int CTRL_INTERNAL_TEMP_SELECT_BIT = 0;
   localparam int CTRL_LEARNED_BIT = 1;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_HALF_BIT = 1;
   localparam int STAT_DIV_BIT = 2;

   // ***********************************************
   // reset values
   // ***********************************************
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [7:0] BIAS_RST = 8'h00;
   localparam logic [7:0] BLANK_RST = 8'h06;
   localparam logic [7:0] SCALE_RST = 8'h00;
   localparam logic [7:0] BASE_CAP_RST = 8'h00;
   localparam logic [15:0] RESULT_RST = 16'h0000;

   typedef enum {ST_IDLE, ST_VOLT, ST_CUR, ST_SETTLE, ST_AUX, ST_WAIT} gms_state_e;
   typedef enum logic [2:0] {CH_VOLT, CH_CUR, CH_AUX0, CH_AUX1, CH_TEMP, CH_VOFS, CH_IOFS}
      gms_chan_e;

endpackage

// *** gms_conv_model.sv ***
module gms_conv_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic adc_start,
   input wire gms_pkg::gms_chan_e adc_sel,
   input wire logic [3:0] lat,
   input wire logic [15:0] volt_val,
   input wire logic [15:0] cur_val,
   input wire logic [15:0] aux_val,
   input wire logic [15:0] ofs_val,
   output logic adc_done,
   output logic [15:0] adc_data
);
   timeunit 1ns;
   timeprecision 1ns;
   import gms_pkg::*;
   // ****************************************
   // converter and analog front end
   // ****************************************
   int cnt;
   logic [15:0] val;
   logic fire;
   // sample per channel; aux one and temp sit just above aux zero
   always_comb begin
      case (adc_sel)
         CH_VOLT: val = volt_val;
         CH_CUR: val = cur_val;
         CH_AUX0: val = aux_val;
         CH_AUX1: val = aux_val + 16'h0001;
         CH_TEMP: val = aux_val + 16'h0002;
         default: val = ofs_val;
      endcase
   end
   // answers lat cycles after start; idle data line toggles each cycle
   always @(posedge sys_clk) begin
      fire = !srst && !adc_start && cnt == 1;
      if (srst) begin
         cnt = 0;
      end else if (adc_start) begin
         cnt = lat;
      end else if (cnt > 0) begin
         cnt = cnt - 1;
      end
      adc_done <= fire;
      adc_data <= srst ? 16'h0000 : (fire ? val : ~adc_data);
   end
endmodule // gms_conv_model

// *** gms_sequencer_tb_top.sv ***
module gms_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import gms_pkg::*;
   localparam int HALF = 40;
   localparam int SET = 4;
   localparam logic [7:0] BS [6] = '{8'h00, 8'h05, 8'h05, 8'hfb, 8'h05, 8'h05};
   localparam logic [15:0] CV [6] = '{16'hff9c, 16'hff9c, 16'h0, 16'h00c8, 16'hf000, 16'h1000};
   localparam logic [31:0] AP [6] = '{32'h0, ACC_LIMIT - 32'sh32, 32'h0, 32'sh64 - ACC_LIMIT,
      32'h0, 32'h0};
   localparam logic [31:0] EC [6] = '{32'h0640, 32'h0690, 32'h0050, 32'hf330, 32'h7fff, 32'h8000};
   localparam logic [31:0] EA [6] = '{32'h64, ACC_LIMIT, 32'h0, -ACC_LIMIT, 32'h7ff, 32'hfffff800};
   localparam logic [31:0] ER [6] = '{32'h20, 32'hc8, 32'h20, 32'h0, 32'h20, 32'h20};
   logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, active_mode;
   logic adc_start, adc_done, divider_supply_out;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [15:0] adc_data, volt_val, cur_val, aux_val, ofs_val;
   logic [3:0] lat;
   gms_chan_e adc_sel, got_sel;
   int bad_count, total_checks, cyc, vcount, scount, dcnt, t0, s0;

   gms_sequencer #(.HALF_CYCLES(HALF), .SETTLE_CYCLES(SET)) u_gms_sequencer (
      .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .active_mode(active_mode), .adc_start(adc_start),
      .adc_sel(adc_sel), .adc_done(adc_done), .adc_data(adc_data),
      .divider_supply_out(divider_supply_out));
   gms_conv_model u_gms_conv_model (
      .sys_clk(sys_clk), .srst(srst), .adc_start(adc_start), .adc_sel(adc_sel), .lat(lat),
      .volt_val(volt_val), .cur_val(cur_val), .aux_val(aux_val), .ofs_val(ofs_val),
      .adc_done(adc_done), .adc_data(adc_data));

   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // cycle stamp, divider on-time, start counts
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      dcnt <= divider_supply_out ? dcnt + 1 : 0;
      if (adc_start) scount <= scount + 1;
      if (adc_start && adc_sel == CH_VOLT) vcount <= vcount + 1;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic summarize();
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic fail();
      bad_count++;
      $display("ERROR %0t wait ran out", $time);
      summarize();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      if (n >= 20) fail();
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   // wait for a conversion start on any channel in the mask
   task automatic ws(input logic [7:0] mask);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!(adc_start === 1'b1 && mask[adc_sel] === 1'b1) && n < 50000);
      got_sel = adc_sel;
      if (n >= 50000) fail();
   endtask
   // wait for the aux slot of a second half
   task automatic wsec();
      ws(8'h1c);
      if (got_sel === CH_AUX0) ws(8'h1c);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_reset();
      rd(A_BIAS, 32'h0);
      rd(A_BLANK, 32'h6);
      wr(A_VOLT, 32'h5555);
      rd(A_VOLT, 32'h0);
      rd(8'h3c, 32'h0);
      chk(scount, 0);
   endtask
   task automatic s_order();
      active_mode <= 1'b1;
      ws(8'h01);
      t0 = cyc;
      ws(8'h02);
      ws(8'h1c);
      chk(got_sel, CH_AUX0);
      chk(divider_supply_out, 1'b1);
      chk(dcnt >= SET, 1'b1);
      rd(A_CUR, 32'h0640);
      rd(A_VOLT, 32'h1234);
      ws(8'h01);
      chk(cyc - t0, HALF);
      rd(A_AUX0, 32'h0321);
      ws(8'h1c);
      chk(got_sel, CH_AUX1);
      ws(8'h01);
      chk(cyc - t0, 2 * HALF);
      rd(A_AUX1, 32'h0322);
   endtask
   // bias, saturation, blanking, counter clamps and capacity, one row per half
   task automatic s_cur();
      lat <= 4'h2;
      ws(8'h1c);
      wr(A_INIT_SCALE, 32'h10);
      wr(A_BASE_CAP, 32'h20);
      for (int i = 0; i < 6; i++) begin
         wr(A_BIAS, {24'h0, BS[i]});
         wr(A_ACC, AP[i]);
         cur_val <= CV[i];
         ws(8'h1c);
         rd(A_CUR, EC[i]);
         rd(A_ACC, EA[i]);
         rd(A_REL_CAP, ER[i]);
      end
   endtask
   task automatic s_temp();
      wr(A_CTRL, 32'h1);
      wsec();
      chk(got_sel, CH_TEMP);
      chk(dcnt, 0);
      ws(8'h01);
      rd(A_TEMP, 32'h0323);
      wr(A_CTRL, 32'h0);
      wsec();
      chk(got_sel, CH_AUX1);
   endtask
   task automatic s_offset();
      ws(8'h20);
      chk(vcount, 1023);
      ws(8'h42);
      chk(got_sel, CH_IOFS);
      rd(A_VOLT, 32'h1234);
      rd(A_CUR, 32'h8000);
      volt_val <= 16'h7ff8;
      cur_val <= 16'hff8c;
      ws(8'h01);
      ws(8'h1c);
      rd(A_VOLT, 32'h7fff);
      rd(A_CUR, 32'h0690);
   endtask
   task automatic s_sleep();
      active_mode <= 1'b0;
      repeat (3) @(posedge sys_clk);
      s0 = scount;
      repeat (200) @(posedge sys_clk);
      chk(scount - s0, 0);
      rd(A_VOLT, 32'h7fff);
      active_mode <= 1'b1;
      ws(8'h01);
   endtask

   // main sequence
   initial begin
      srst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      active_mode = 1'b0;
      lat = 4'h6;
      volt_val = 16'h1234;
      cur_val = 16'hff9c;
      aux_val = 16'h0321;
      ofs_val = 16'hfff0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      s_reset();
      s_order();
      s_cur();
      s_temp();
      s_offset();
      s_sleep();
      summarize();
   end
endmodule // gms_sequencer_tb_top
